// [include/space_decode_pkg.sv]
// Constants for the host-to-controller space decoder.
// Assumes a single 100 MHz core clock and an active-low async reset.
`default_nettype none

package space_decode_pkg;

	localparam int unsigned HOST_ADDR_W     = 32;
	localparam int unsigned MEM_ADDR_W      = 24;
	localparam int unsigned IO_ADDR_W       = 16;
	localparam int unsigned IO_BIT_SIXTEEN  = 16;
	localparam int unsigned REG_PAIR_SPAN_W = 1;

	// Region bases in the host map, taken above the passed address lines.
	localparam logic [7:0]  MEM_REGION_BASE = 8'h10;
	localparam logic [15:0] IO_REGION_BASE  = 16'h2000;
	localparam logic [15:0] REG_REGION_BASE = 16'h2001;

	// Index/data pair offsets inside the I/O space, chosen by a strap.
	localparam logic [15:0] PAIR_OFFSET_LOW  = 16'h03e0;
	localparam logic [15:0] PAIR_OFFSET_HIGH = 16'h03e2;

	// Settle time after a cycle start before selects may be used.
	localparam int unsigned SETTLE_NS    = 125;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SETTLE_CYCLES =
		(SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// System clock of nominally 8 MHz is a 12-cycle, 120 ns period enable.
	localparam int unsigned SYS_PERIOD_NS = 125;
	localparam int unsigned SYS_DIV_CYCLES = SYS_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		SPACE_NONE,
		SPACE_IO,
		SPACE_MEM,
		SPACE_REG
	} space_type;

endpackage : space_decode_pkg

`default_nettype wire

// [src/sys_tick_divider.sv]
// One-cycle enable pulse at the nominal system clock rate.
// Assumes core_clk is the only clock; rst_b is async active low.
`default_nettype none

module sys_tick_divider
	import space_decode_pkg::*;
#(
	parameter int unsigned DIV = SYS_DIV_CYCLES
)
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_b,
	// Enable pulse
	output logic      sys_tick
);

	logic [7:0] count_r;
	logic [7:0] count_nxt;

	always_comb
	begin
		if (count_r == 8'(DIV - 1))
			count_nxt = 8'h00;
		else
			count_nxt = count_r + 8'h01;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			count_r <= 8'h00;
		else
			count_r <= count_nxt;
	end

	assign sys_tick = (count_r == 8'(DIV - 1));

endmodule : sys_tick_divider

`default_nettype wire

// [src/isa_space_address_decode.sv]
// Host address decoder producing three active-low space selects.
// Assumes host address, strobe and strap are synchronous to core_clk.
//
// What this block does
// - Drive separate selects for I/O space, memory space and register space.
// - Memory select compares host address bits above the 24 passed lines.
// - I/O uses 16 lines; bit sixteen forced zero; upper bits decoded.
// - Register select yields an I/O cycle; it may be disabled.
// - Index/data pair sits at 3E0/3E1 or 3E2/3E3 by strap.
// - Timing derives from core_clk; a nominal 8 MHz system tick is divided from it.
// - Selects assert one cycle after strobe; decode_settled flags the settle wait from cycle start.
`default_nettype none

module isa_space_address_decode
	import space_decode_pkg::*;
#(
	parameter int unsigned ADDR_W = HOST_ADDR_W
)
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// Host bus
	input  wire logic [ADDR_W-1:0] host_addr,
	input  wire logic              addr_strobe_n,
	// Configuration
	input  wire logic              reg_select_enable,
	input  wire logic              pair_strap_high,
	// Space selects, address bit sixteen, pair hit, settle flag and system tick
	output logic                   io_space_select_n,
	output logic                   memory_space_select_n,
	output logic                   ctrl_register_space_select_n,
	output logic                   io_addr_bit_sixteen,
	output logic                   index_pair_hit,
	output logic                   decode_settled,
	output logic                   sys_tick
);

	////////////////////////////////////////////////////////////////////////
	// Region decode
	//
	// The upper host address lines that the controller never sees pick the
	// region. Memory wins over I/O and I/O over the register page, although
	// the bases chosen here keep the three regions apart anyway.

	logic        mem_hit;
	logic        io_hit;
	logic        reg_hit;
	space_type   space_raw;
	logic        pair_raw;
	logic [15:0] pair_base;

	assign mem_hit =
		(host_addr[ADDR_W-1:MEM_ADDR_W] == MEM_REGION_BASE);
	assign io_hit =
		(host_addr[ADDR_W-1:IO_ADDR_W] == IO_REGION_BASE);
	// The register page can be switched off; it sits in its own region above I/O.
	assign reg_hit = reg_select_enable
		&& (host_addr[ADDR_W-1:IO_ADDR_W] == REG_REGION_BASE);

	always_comb
	begin
		space_raw = SPACE_NONE;
		if (mem_hit)
		begin
			space_raw = SPACE_MEM;
		end
		else if (io_hit)
		begin
			space_raw = SPACE_IO;
		end
		else if (reg_hit)
		begin
			space_raw = SPACE_REG;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Index and data pair decode
	//
	// The strap moves the pair between its two homes; the lowest address bit
	// then tells the index register from the data register.

	assign pair_base = pair_strap_high ? PAIR_OFFSET_HIGH
		: PAIR_OFFSET_LOW;

	// Register accesses hit the pair within the register region too.
	assign pair_raw = (space_raw == SPACE_IO || space_raw == SPACE_REG)
		&& host_addr[IO_ADDR_W-1:REG_PAIR_SPAN_W]
		== pair_base[IO_ADDR_W-1:REG_PAIR_SPAN_W];

	////////////////////////////////////////////////////////////////////////
	// Settle counter
	//
	// The count restarts whenever the strobe is high, so a new cycle never
	// inherits the settle time of the cycle before it. The bus logic that
	// issues the command strobes waits for the settled flag.

	logic [7:0] settle_r;
	logic [7:0] settle_nxt;
	logic       cycle_live;

	assign cycle_live = !addr_strobe_n;

	always_comb
	begin
		settle_nxt = settle_r;
		if (!cycle_live)
		begin
			settle_nxt = 8'h00;
		end
		else if (settle_r != 8'(SETTLE_CYCLES))
		begin
			settle_nxt = settle_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			settle_r <= 8'h00;
		end
		else
		begin
			settle_r <= settle_nxt;
		end
	end

	assign decode_settled = (settle_r == 8'(SETTLE_CYCLES));

	////////////////////////////////////////////////////////////////////////
	// Select, pair and address line next values
	//
	// Every select is fed from the one encoded space value, which keeps the
	// three mutually exclusive whatever the host address does. While the
	// strobe is high all of them fall back to their idle levels.

	localparam int unsigned N_SEL = 3;
	localparam space_type SEL_SPACE [N_SEL] =
		'{SPACE_IO, SPACE_MEM, SPACE_REG};

	logic [N_SEL-1:0] sel_n_r;
	logic [N_SEL-1:0] sel_n_nxt;
	logic             pair_r;
	logic             pair_nxt;
	logic             bit_sixteen_r;
	logic             bit_sixteen_nxt;

	for (genvar g = 0; g < N_SEL; g++)
	begin : g_sel
		assign sel_n_nxt[g] =
			!(cycle_live && space_raw == SEL_SPACE[g]);
	end : g_sel

	// Only a memory cycle carries host bit sixteen to the controller; the
	// I/O and register cycles see it held low.
	always_comb
	begin
		pair_nxt        = 1'b0;
		bit_sixteen_nxt = 1'b0;
		if (cycle_live)
		begin
			pair_nxt = pair_raw;
			if (space_raw == SPACE_MEM)
			begin
				bit_sixteen_nxt = host_addr[IO_BIT_SIXTEEN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Select, pair and address line registers

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sel_n_r       <= {N_SEL{1'b1}};
			pair_r        <= 1'b0;
			bit_sixteen_r <= 1'b0;
		end
		else
		begin
			sel_n_r       <= sel_n_nxt;
			pair_r        <= pair_nxt;
			bit_sixteen_r <= bit_sixteen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	//
	// All pins below come straight from flip-flops, so the controller sees
	// no decode glitches while the host address is still moving.

	assign io_space_select_n            = sel_n_r[0];
	assign memory_space_select_n        = sel_n_r[1];
	assign ctrl_register_space_select_n = sel_n_r[2];
	assign io_addr_bit_sixteen          = bit_sixteen_r;
	assign index_pair_hit               = pair_r;

	////////////////////////////////////////////////////////////////////////
	// System time base
	//
	// The tick paces the command timing of the bus logic. It runs freely
	// from reset and is not tied to the strobe.

	sys_tick_divider #(
		.DIV(SYS_DIV_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.rst_b   (rst_b),
		.sys_tick(sys_tick)
	);

endmodule : isa_space_address_decode

`default_nettype wire

// [dv/ctrl_chip_model.sv]
// Controller model: notes the space of each settled access.
// Assumes the selects come straight from the decoder.
`default_nettype none
module ctrl_chip_model
	import space_decode_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic io_n,
	input  wire logic mem_n,
	input  wire logic reg_n,
	input  wire logic settled,
	output var  space_type space
);
	always_ff @(posedge core_clk)
		if (settled)
			space <= !mem_n ? SPACE_MEM : !io_n ? SPACE_IO
				: !reg_n ? SPACE_REG : SPACE_NONE;
endmodule : ctrl_chip_model
`default_nettype wire

// [dv/isa_space_decode_monitor.sv]
// Port checks for the space decoder.
// Assumes it is bound to the decoder top.
`default_nettype none
module isa_space_decode_monitor
	import space_decode_pkg::*;
#(
	parameter int unsigned ADDR_W = HOST_ADDR_W
)
(
	input wire logic core_clk, rst_b, addr_strobe_n, reg_select_enable,
	input wire logic pair_strap_high, io_space_select_n, sys_tick,
	input wire logic memory_space_select_n, ctrl_register_space_select_n,
	input wire logic io_addr_bit_sixteen, index_pair_hit, decode_settled,
	input wire logic [ADDR_W-1:0] host_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire tk = !addr_strobe_n;
	wire mh = host_addr[31:24] == MEM_REGION_BASE;
	wire ih = host_addr[31:16] == IO_REGION_BASE;
	wire rh = host_addr[31:16] == REG_REGION_BASE && reg_select_enable;
	wire pr = host_addr[15:2] == PAIR_OFFSET_LOW[15:2]
		&& host_addr[1] == pair_strap_high;
	wire [2:0] sel = {io_space_select_n, memory_space_select_n,
		ctrl_register_space_select_n};
	property p_mem; tk && mh |=> sel == 3'b101; endproperty
	a_mem: assert property (p_mem) else $error("mem select");
	property p_io; tk && ih |=> sel == 3'b011; endproperty
	a_io: assert property (p_io) else $error("io select");
	property p_b16; !(tk && mh) |=> !io_addr_bit_sixteen; endproperty
	a_b16: assert property (p_b16) else $error("bit 16 set");
	property p_b16m;
		tk && mh |=> io_addr_bit_sixteen == $past(host_addr[16]);
	endproperty
	a_b16m: assert property (p_b16m) else $error("bit 16 lost");
	property p_excl; $countones(~sel) <= 1; endproperty
	a_excl: assert property (p_excl) else $error("select clash");
	property p_reg; tk && rh |=> sel == 3'b110; endproperty
	a_reg: assert property (p_reg) else $error("reg select");
	property p_none; tk && !mh && !ih && !rh |=> &sel; endproperty
	a_none: assert property (p_none) else $error("stray select");
	property p_pair; tk && (ih || rh) |=> index_pair_hit == $past(pr);
	endproperty
	a_pair: assert property (p_pair) else $error("pair hit");
	property p_idle; addr_strobe_n |=> &sel && !decode_settled; endproperty
	a_idle: assert property (p_idle) else $error("idle select");
	property p_tick; sys_tick |=> !sys_tick [*8]; endproperty
	a_tick: assert property (p_tick) else $error("tick rate");
endmodule : isa_space_decode_monitor
`default_nettype wire

// [dv/isa_space_address_decode_bench.sv]
// Self-checking bench for the space decoder.
// Assumes package, decoder, monitor and chip model compiled first.
`default_nettype none
module isa_space_address_decode_bench
	import space_decode_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_b = 0, as_n = 1, en = 1, strap = 0;
	logic [31:0] addr = '0;
	logic io_n, mem_n, reg_n, a16, hit, settled, tick;
	space_type space;
	int n_fail = 0, tests_run = 0;
	isa_space_address_decode DUT (.core_clk, .rst_b, .host_addr(addr),
		.addr_strobe_n(as_n), .reg_select_enable(en),
		.pair_strap_high(strap), .io_space_select_n(io_n),
		.memory_space_select_n(mem_n), .io_addr_bit_sixteen(a16),
		.ctrl_register_space_select_n(reg_n), .index_pair_hit(hit),
		.decode_settled(settled), .sys_tick(tick));
	ctrl_chip_model u_chip (.core_clk, .io_n, .mem_n, .reg_n, .settled,
		.space);
	initial forever #5 core_clk = ~core_clk;
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic bad(input string m);
		n_fail++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : bad
	task automatic chk(input logic [31:0] a, input logic s, e,
		input logic [4:0] x, input space_type sp);
		int i;
		@(posedge core_clk);
		{as_n, addr, strap, en} <= {1'b0, a, s, e};
		@(posedge core_clk);
		#1;
		tests_run += 3;
		if ({io_n, mem_n, reg_n, hit, a16, settled} !== {x, 1'b0})
			bad("selects");
		for (i = 0; i < 20 && settled !== 1'b1; i++)
		begin
			@(posedge core_clk);
			#1;
		end
		if (i == 20)
		begin
			bad("no settle");
			conclude();
		end
		@(posedge core_clk);
		#1;
		if (space !== sp)
			bad("space");
		@(posedge core_clk);
		as_n <= 1;
		@(posedge core_clk);
		#1;
		if ({io_n, mem_n, reg_n, hit, a16, settled} !== 6'h38)
			bad("idle");
	endtask : chk
	task automatic t_reset();
		@(posedge core_clk);
		{as_n, addr, en} <= {1'b0, 32'h1000_0000, 1'b1};
		@(posedge core_clk);
		#1;
		tests_run += 3;
		if (mem_n !== 1'b0)
			bad("no select before reset");
		@(posedge core_clk);
		{rst_b, as_n} <= 2'b01;
		#1;
		if ({io_n, mem_n, reg_n, hit, a16, settled, tick} !== 7'h70)
			bad("reset values");
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		repeat (2) @(posedge core_clk);
		#1;
		if ({io_n, mem_n, reg_n, hit, settled} !== 5'h1c)
			bad("after reset");
		$display("mid-run reset test done");
	endtask : t_reset
	task automatic t_tick();
		int n;
		for (n = 0; n < 40 && tick !== 1'b1; n++)
		begin
			@(posedge core_clk);
			#1;
		end
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			#1;
			if (tick === 1'b1)
				break;
		end
		tests_run++;
		if (n + 1 != SYS_DIV_CYCLES)
			bad("tick period");
		$display("system tick test done");
	endtask : t_tick
	task automatic t_mem();
		chk(32'h1000_0000, 0, 1, 5'b10100, SPACE_MEM);
		chk(32'h1100_0000, 0, 1, 5'b11100, SPACE_NONE);
		chk(32'h1001_0000, 0, 1, 5'b10101, SPACE_MEM);
		$display("memory space test done");
	endtask : t_mem
	task automatic t_io();
		chk(32'h2000_03e0, 0, 1, 5'b01110, SPACE_IO);
		chk(32'h2000_03e3, 1, 1, 5'b01110, SPACE_IO);
		chk(32'h2000_03e2, 0, 1, 5'b01100, SPACE_IO);
		chk(32'h2001_03e1, 0, 1, 5'b11010, SPACE_REG);
		chk(32'h2001_03e1, 0, 0, 5'b11100, SPACE_NONE);
		chk(32'h2000_03e1, 0, 0, 5'b01110, SPACE_IO);
		chk(32'h2000_0300, 0, 1, 5'b01100, SPACE_IO);
		chk(32'h2000_03e2, 1, 1, 5'b01110, SPACE_IO);
		chk(32'h2000_03e0, 1, 1, 5'b01100, SPACE_IO);
		chk(32'h2001_03e1, 1, 1, 5'b11000, SPACE_REG);
		chk(32'h2002_03e0, 0, 1, 5'b11100, SPACE_NONE);
		$display("io and register space test done");
	endtask : t_io
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1;
		t_mem();
		t_io();
		t_reset();
		t_tick();
		conclude();
	end
endmodule : isa_space_address_decode_bench
bind isa_space_address_decode isa_space_decode_monitor #(.ADDR_W(ADDR_W))
	u_mon (.core_clk(core_clk), .rst_b(rst_b), .host_addr(host_addr),
		.addr_strobe_n(addr_strobe_n),
		.reg_select_enable(reg_select_enable),
		.pair_strap_high(pair_strap_high),
		.io_space_select_n(io_space_select_n),
		.memory_space_select_n(memory_space_select_n),
		.ctrl_register_space_select_n(ctrl_register_space_select_n),
		.io_addr_bit_sixteen(io_addr_bit_sixteen),
		.index_pair_hit(index_pair_hit),
		.decode_settled(decode_settled), .sys_tick(sys_tick));
`default_nettype wire
